// ==== design/fbpa_pkg.sv ====
// constants and register map of the five bit port a block
package fbpa_pkg;
	localparam int FBPA_PINS = 5;
	localparam logic [7:0] FBPA_OFS_DATA = 8'h05;
	localparam logic [7:0] FBPA_OFS_CMP = 8'h1f;
	localparam logic [7:0] FBPA_OFS_DIR = 8'h85;
	localparam logic [7:0] FBPA_OFS_VREF = 8'h9f;
	localparam logic [4:0] FBPA_DIR_RST = 5'h1f;
	localparam logic [4:0] FBPA_LATCH_RST = 5'h00;
	localparam logic [4:0] FBPA_CMP_RST = 5'h00;
	localparam logic [6:0] FBPA_VREF_RST = 7'h00;
	// comparator mode field, low three bits of comparator control
	localparam logic [2:0] FBPA_CM_RESET = 3'h0;
	localparam logic [2:0] FBPA_CM_OFF = 3'h7;
	localparam logic [2:0] FBPA_CM_OUTS = 3'h6;
	localparam int FBPA_CM_CIS_BIT = 3;
	localparam int FBPA_VREF_OE_BIT = 6;
	localparam int FBPA_VREF_EN_BIT = 7;
	localparam int FBPA_VREF_RR_BIT = 5;
endpackage

// ==== design/fbpa_port.sv ====
// five bit general purpose port a with comparator and reference sharing
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps

module fbpa_port
	import fbpa_pkg::*;
#(
	parameter int PINS = FBPA_PINS
)
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic [PINS-1:0] pin_in,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe,
	input wire logic [1:0] cmp_result,
	output logic timer_external_clock_input,
	output logic [2:0] cmp_mode,
	output logic cmp_input_switch,
	output logic [PINS-1:0] analog_select,
	output logic [3:0] vref_level,
	output logic vref_enable,
	output logic vref_range,
	output logic vref_drive_pin
);

	// ========================================
	// state
	logic [PINS-1:0] latch;
	logic [PINS-1:0] dir;
	logic [4:0] cmp_ctl;
	logic [7:0] vref_ctl;
	logic [PINS-1:0] pin_s1;
	logic [PINS-1:0] pin_s2;

	// ========================================
	// decode
	wire sel_data = addr == FBPA_OFS_DATA;
	wire sel_cmp = addr == FBPA_OFS_CMP;
	wire sel_dir = addr == FBPA_OFS_DIR;
	wire sel_vref = addr == FBPA_OFS_VREF;
	wire [2:0] cm = cmp_ctl[2:0];
	wire cmp_off = cm == FBPA_CM_OFF;
	wire cmp_gnd = cm == FBPA_CM_RESET;
	wire cmp_outs = cm == FBPA_CM_OUTS;
	// analog pins from mode
	// pins zero to three are analog unless comparators are off; mode six
	// keeps pins three and four as comparator outputs, not inputs
	wire [PINS-1:0] ana_in = cmp_off ? '0 :
		(cmp_outs ? {2'b00, 3'b111} : {1'b0, 4'b1111});
	wire vref_pin = vref_ctl[FBPA_VREF_OE_BIT] & vref_ctl[FBPA_VREF_EN_BIT];

	// ========================================
	// pin drive
	logic [PINS-1:0] drv_val;
	always_comb
	begin
		drv_val = latch;
		if (cmp_outs)
		begin
			drv_val[3] = cmp_result[0];
			drv_val[4] = cmp_result[1];
		end
	end

	// high on pin four is z
	wire [PINS-1:0] next_oe = ~dir & {~drv_val[4], 4'b1111};
	wire [PINS-1:0] next_out = drv_val & 5'h0f;

	wire [PINS-1:0] pin_view = pin_s2 & ~ana_in;

	wire [7:0] rd_mux = sel_data ? {3'h0, pin_view} :
		sel_dir ? {3'h0, dir} :
		sel_cmp ? {cmp_result[1], cmp_result[0], 2'b00, cmp_ctl[3:0]} :
		sel_vref ? vref_ctl : 8'h00;

	// ========================================
	// input synchroniser
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end
		else if (clk_en)
		begin
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
		end
	end

	// ========================================
	// registers
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			dir <= FBPA_DIR_RST;
			latch <= FBPA_LATCH_RST;
			cmp_ctl <= FBPA_CMP_RST;
			vref_ctl <= {FBPA_VREF_RST[6:4], 1'b0, FBPA_VREF_RST[3:0]};
		end
		else if (clk_en && wr)
		begin
			// data and direction writes store the low five bits of the byte; upper three dropped
			// the cpu already merged sampled pins into wdata before the write
			if (sel_data)
				latch <= wdata[PINS-1:0];
			if (sel_dir)
				dir <= wdata[PINS-1:0];
			// bit four of both control registers is unimplemented; comparator control also has no bit five
			if (sel_cmp)
				cmp_ctl <= {1'b0, wdata[3:0]};
			if (sel_vref)
				vref_ctl <= {wdata[7:5], 1'b0, wdata[3:0]};
		end
	end

	// ========================================
	// outputs
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata <= 8'h00;
			pin_out <= '0;
			pin_oe <= '0;
			timer_external_clock_input <= 1'b0;
			cmp_mode <= FBPA_CM_RESET;
			cmp_input_switch <= 1'b0;
			analog_select <= '0;
			vref_level <= 4'h0;
			vref_enable <= 1'b0;
			vref_range <= 1'b0;
			vref_drive_pin <= 1'b0;
		end
		else if (clk_en)
		begin
			rdata <= rd ? rd_mux : 8'h00;
			pin_out <= next_out;
			pin_oe <= next_oe;
			timer_external_clock_input <= pin_s2[4];
			cmp_mode <= cm;
			cmp_input_switch <= cmp_ctl[FBPA_CM_CIS_BIT];
			analog_select <= cmp_gnd ? '0 : ana_in;
			vref_level <= vref_ctl[3:0];
			vref_enable <= vref_ctl[FBPA_VREF_EN_BIT];
			vref_range <= vref_ctl[FBPA_VREF_RR_BIT];
			vref_drive_pin <= vref_pin;
		end
	end

	// ========================================
	// checks
	// released pin
	property p_dir_release;
		@(posedge mclk) disable iff (!nrst)
		clk_en && dir[0] |=> !pin_oe[0];
	endproperty
	a_dir_release: assert property (p_dir_release) else $error("input pin driven");

	property p_drive_latch;
		@(posedge mclk) disable iff (!nrst)
		clk_en && !dir[1] |=> pin_oe[1] && pin_out[1] == $past(latch[1]);
	endproperty
	a_drive_latch: assert property (p_drive_latch) else $error("pin not latch");

	property p_open_drain;
		@(posedge mclk) disable iff (!nrst)
		!(pin_oe[4] && pin_out[4]);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("pin four high");

	property p_od_release;
		@(posedge mclk) disable iff (!nrst)
		clk_en && latch[4] && !cmp_outs |=> !pin_oe[4];
	endproperty
	a_od_release: assert property (p_od_release) else $error("pin four not released");

	property p_dir_upper;
		@(posedge mclk) disable iff (!nrst)
		clk_en && rd && sel_dir |=> rdata[7:5] == 3'h0 && rdata[4:0] == $past(dir);
	endproperty
	a_dir_upper: assert property (p_dir_upper) else $error("direction read wrong");

	property p_ana_zero;
		@(posedge mclk) disable iff (!nrst)
		clk_en && rd && sel_data && !cmp_off |=> rdata[2:0] == 3'h0;
	endproperty
	a_ana_zero: assert property (p_ana_zero) else $error("analog pin read");

	property p_read_pins;
		@(posedge mclk) disable iff (!nrst)
		clk_en && rd && sel_data && cmp_off |=> rdata == {3'h0, $past(pin_s2)};
	endproperty
	a_read_pins: assert property (p_read_pins) else $error("pin read wrong");

	property p_latch_wr;
		@(posedge mclk) disable iff (!nrst)
		clk_en && wr && sel_data |=> latch == $past(wdata[4:0]);
	endproperty
	a_latch_wr: assert property (p_latch_wr) else $error("latch not written");

	property p_timer_clk;
		@(posedge mclk) disable iff (!nrst)
		clk_en |=> timer_external_clock_input == $past(pin_s2[4]);
	endproperty
	a_timer_clk: assert property (p_timer_clk) else $error("timer clock stale");

	// ========================================
	// further checks
	// low pins drive
	property p_oe_low_pins;
		@(posedge mclk) disable iff (!nrst)
		clk_en && !dir[0] |=> pin_oe[0];
	endproperty
	a_oe_low_pins: assert property (p_oe_low_pins) else $error("pin zero not driven");

	property p_push_pull_hi;
		@(posedge mclk) disable iff (!nrst)
		clk_en && !dir[2] && latch[2] |=> pin_oe[2] && pin_out[2];
	endproperty
	a_push_pull_hi: assert property (p_push_pull_hi) else $error("pin two not high");

	property p_dir_release4;
		@(posedge mclk) disable iff (!nrst)
		clk_en && dir[4] |=> !pin_oe[4];
	endproperty
	a_dir_release4: assert property (p_dir_release4) else $error("pin four driven");

	// reset holds inputs
	// no disable here: the check is about reset itself
	property p_reset_oe;
		@(posedge mclk)
		!nrst && !$past(nrst) |-> pin_oe == '0;
	endproperty
	a_reset_oe: assert property (p_reset_oe) else $error("pin driven in reset");

	property p_reset_ana;
		@(posedge mclk)
		!nrst && !$past(nrst) |-> analog_select == '0;
	endproperty
	a_reset_ana: assert property (p_reset_ana) else $error("analog live in reset");

	property p_cmp_gnd;
		@(posedge mclk) disable iff (!nrst)
		clk_en && cmp_gnd |=> analog_select == '0;
	endproperty
	a_cmp_gnd: assert property (p_cmp_gnd) else $error("mode zero not grounded");

	property p_cmp_off_digital;
		@(posedge mclk) disable iff (!nrst)
		clk_en && cmp_off |=> analog_select == '0;
	endproperty
	a_cmp_off_digital: assert property (p_cmp_off_digital) else $error("off mode analog");

	property p_cmp_out_pin3;
		@(posedge mclk) disable iff (!nrst)
		clk_en && cmp_outs && !dir[3] |=> pin_oe[3] && pin_out[3] == $past(cmp_result[0]);
	endproperty
	a_cmp_out_pin3: assert property (p_cmp_out_pin3) else $error("pin three not result");

	property p_cmp_out_pin4;
		@(posedge mclk) disable iff (!nrst)
		clk_en && cmp_outs && !dir[4] |=> pin_oe[4] == !$past(cmp_result[1]);
	endproperty
	a_cmp_out_pin4: assert property (p_cmp_out_pin4) else $error("pin four not result");

	property p_ana_dir;
		@(posedge mclk) disable iff (!nrst)
		clk_en && dir[1] && ana_in[1] |=> !pin_oe[1];
	endproperty
	a_ana_dir: assert property (p_ana_dir) else $error("analog pin driven");

	property p_vref_pin;
		@(posedge mclk) disable iff (!nrst)
		clk_en |=> vref_drive_pin == $past(vref_pin);
	endproperty
	a_vref_pin: assert property (p_vref_pin) else $error("reference pin stale");

	property p_upper_latch;
		@(posedge mclk) disable iff (!nrst)
		clk_en && rd && sel_data |=> rdata[7:5] == 3'h0;
	endproperty
	a_upper_latch: assert property (p_upper_latch) else $error("data upper bits set");

	property p_mode_sel;
		@(posedge mclk) disable iff (!nrst)
		clk_en && !cmp_gnd |=> analog_select == $past(ana_in);
	endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("analog select wrong");

	property p_rdata_idle;
		@(posedge mclk) disable iff (!nrst)
		clk_en && !rd |=> rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	property p_latch_hold;
		@(posedge mclk) disable iff (!nrst)
		!(clk_en && wr && sel_data) |=> $stable(latch);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch moved");

	property p_freeze;
		@(posedge mclk) disable iff (!nrst)
		!clk_en |=> $stable(pin_oe) && $stable(pin_out);
	endproperty
	a_freeze: assert property (p_freeze) else $error("pins moved while frozen");

	c_write_data: cover property (@(posedge mclk) disable iff (!nrst) wr && sel_data);
	c_cmp_gnd: cover property (@(posedge mclk) disable iff (!nrst) cmp_gnd && rd && sel_data);
	c_clk_freeze: cover property (@(posedge mclk) disable iff (!nrst) !clk_en && wr);
	c_cmp_outs: cover property (@(posedge mclk) disable iff (!nrst) cmp_outs && pin_oe[3]);
	c_vref_pin: cover property (@(posedge mclk) disable iff (!nrst) vref_drive_pin);
endmodule

// ==== tb/fbpa_pads.sv ====
// pad model of the circuitry outside the five port pins
`timescale 1ns/1ps
module fbpa_pads
(
	input wire logic [4:0] pin_out,
	input wire logic [4:0] pin_oe,
	input wire logic [4:0] ext,
	output logic [4:0] pin_in
);
	// ==========
	// pad levels
	// enabled driver wins over outside level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// ==== tb/five_bit_port_a_bench.sv ====
// self-checking bench of the five bit port a block
`timescale 1ns/1ps
module five_bit_port_a_bench;
	import fbpa_pkg::*;
	logic mclk = 0, nrst = 0, wr = 0, rd = 0, tck, ce = 1, cis, ven, vrr, vdrv;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got, cv;
	logic [4:0] pin_in, pin_out, pin_oe, ext = 5'h00, dir, lat, pv, asel;
	logic [2:0] cmode;
	logic [3:0] vlvl;
	logic [1:0] cmp_result = 2'h0;
	int fails = 0, compares = 0, seed = 32'h29a5;
	always #20 mclk = ~mclk;
	fbpa_port DUT (.mclk(mclk), .nrst(nrst), .clk_en(ce), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .cmp_result(cmp_result), .timer_external_clock_input(tck),
		.cmp_mode(cmode), .cmp_input_switch(cis), .analog_select(asel), .vref_level(vlvl),
		.vref_enable(ven), .vref_range(vrr), .vref_drive_pin(vdrv));
	fbpa_pads PADS (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
	// ==========
	// tasks
	task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task settle;
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task do_reset;
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		settle();
		check("oe after reset", {3'h0, pin_oe}, 8'h00);
		check("mode after reset", {5'h0, cmode}, 8'h00);
		check("analog after reset", {3'h0, asel}, 8'h00);
		rd_reg(FBPA_OFS_DIR);
		check("dir after reset", got, 8'h1f);
		rd_reg(FBPA_OFS_VREF);
		check("vref after reset", got, 8'h00);
		rd_reg(FBPA_OFS_DATA);
		check("data after reset", got, {3'h0, ext[4], 4'h0});
	endtask
	// pad level expected from direction, latch and outside level
	function automatic logic [4:0] pad(input logic [4:0] d, l, e);
		pad[3:0] = (d[3:0] & e[3:0]) | (~d[3:0] & l[3:0]);
		pad[4] = (!d[4] && !l[4]) ? 1'b0 : e[4];
	endfunction
	// ==========
	// watchdog and main sequence
	initial
	begin
		repeat (20000) @(posedge mclk);
		fails++;
		give_verdict();
	end
	initial
	begin
		do_reset();
		wr_reg(FBPA_OFS_CMP, 8'h07);
		settle();
		check("mode off", {5'h0, cmode}, 8'h07);
		check("off analog", {3'h0, asel}, 8'h00);
		for (int i = 0; i < 10; i++)
		begin
			dir = $random(seed);
			lat = $random(seed);
			ext <= $random(seed);
			wr_reg(FBPA_OFS_DIR, {3'h7, dir});
			wr_reg(FBPA_OFS_DATA, {3'h5, lat});
			settle();
			pv = pad(dir, lat, ext);
			check("oe low pins", {4'h0, pin_oe[3:0]}, {4'h0, ~dir[3:0]});
			check("out low pins", {4'h0, pin_out[3:0]}, {4'h0, lat[3:0]});
			check("oe pin four", {7'h0, pin_oe[4]}, {7'h0, ~dir[4] & ~lat[4]});
			check("out pin four", {7'h0, pin_out[4]}, 8'h00);
			check("timer clock", {7'h0, tck}, {7'h0, pv[4]});
			rd_reg(FBPA_OFS_DATA);
			check("pin read", got, {3'h0, pv});
			rd_reg(FBPA_OFS_DIR);
			check("dir read", got, {3'h0, dir});
		end
		// comparator inputs must stay inputs, so direction is all ones here
		wr_reg(FBPA_OFS_DIR, 8'h1f);
		for (int m = 1; m < 6; m++)
		begin
			// odd modes also set the input switch bit
			cv = 8'(m) | (m[0] ? 8'h08 : 8'h00);
			ext <= $random(seed);
			cmp_result <= $random(seed);
			wr_reg(FBPA_OFS_CMP, cv);
			settle();
			check("mode out", {5'h0, cmode}, {5'h0, cv[2:0]});
			check("input switch", {7'h0, cis}, {7'h0, cv[3]});
			check("analog select", {3'h0, asel}, 8'h0f);
			rd_reg(FBPA_OFS_DATA);
			check("analog read", got, {3'h0, ext[4], 4'h0});
			rd_reg(FBPA_OFS_CMP);
			check("cmp read", got, {cmp_result, 6'(cv)});
		end
		wr_reg(FBPA_OFS_DIR, 8'h07);
		wr_reg(FBPA_OFS_CMP, 8'h06);
		for (int i = 0; i < 4; i++)
		begin
			cmp_result <= 2'(i);
			settle();
			check("cmp out pin", {6'h0, pin_oe[3], pin_out[3]}, {7'h1, cmp_result[0]});
			check("cmp out od", {7'h0, pin_oe[4]}, {7'h0, ~cmp_result[1]});
			check("mode six analog", {3'h0, asel}, 8'h07);
		end
		wr_reg(FBPA_OFS_VREF, 8'hff);
		rd_reg(FBPA_OFS_VREF);
		check("vref read", got, 8'hef);
		check("vref outs", {ven, vdrv, vrr, 1'b0, vlvl}, 8'hef);
		// a write while the clock enable is low must not land
		ce <= 1'b0;
		wr_reg(FBPA_OFS_DIR, 8'h1f);
		ce <= 1'b1;
		rd_reg(FBPA_OFS_DIR);
		check("frozen dir", got, 8'h07);
		rd_reg(8'h40);
		check("unmapped", got, 8'h00);
		do_reset();
		give_verdict();
	end
endmodule
